/* shared/aid_pkg.sv */
package aid_pkg;

  // operation classes
  typedef enum logic [3:0] {
    AID_OP_NONE     = 4'h0,
    AID_OP_SUM      = 4'h1,
    AID_OP_SUM_C    = 4'h2,
    AID_OP_DIFF     = 4'h3,
    AID_OP_DIFF_B   = 4'h4,
    AID_OP_COMPARE  = 4'h5,
    AID_OP_ASCII_SA = 4'h6,
    AID_OP_BCD_SA   = 4'h7,
    AID_OP_ASCII_DA = 4'h8,
    AID_OP_BCD_DA   = 4'h9,
    AID_OP_UPROD    = 4'hA,
    AID_OP_SPROD    = 4'hB,
    AID_OP_SPROD_I  = 4'hC,
    AID_OP_UQUOT    = 4'hD
  } aid_op_t;

  // operand forms
  typedef enum logic [1:0] {
    AID_FORM_RM  = 2'h0,
    AID_FORM_IMM = 2'h1,
    AID_FORM_ACC = 2'h2,
    AID_FORM_ONE = 2'h3
  } aid_form_t;

  // decoded instruction handed to the datapath
  typedef struct packed {
    aid_op_t   op;
    aid_form_t form;
    logic      word;
    logic      reg_is_dst;
    logic      mem;
    logic [2:0] reg_f;
    logic [2:0] rm_f;
    logic [1:0] mod_f;
    logic [15:0] imm;
    logic [5:0] clk_min;
    logic [5:0] clk_max;
  } aid_dec_t;

  // fixed opcode patterns and field positions
  localparam logic [7:0] AID_OPC_ASCII_SA = 8'h37;
  localparam logic [7:0] AID_OPC_BCD_SA   = 8'h27;
  localparam logic [7:0] AID_OPC_ASCII_DA = 8'h3F;
  localparam logic [7:0] AID_OPC_BCD_DA   = 8'h2F;
  localparam logic [5:0] AID_PFX_SUM      = 6'h00;
  localparam logic [5:0] AID_PFX_SUM_C    = 6'h04;
  localparam logic [5:0] AID_PFX_DIFF     = 6'h0A;
  localparam logic [5:0] AID_PFX_DIFF_B   = 6'h06;
  localparam logic [6:0] AID_PFX_CMP_RM   = 7'h1D;
  localparam logic [6:0] AID_PFX_CMP_MR   = 7'h1C;
  localparam logic [6:0] AID_PFX_SUM_A    = 7'h02;
  localparam logic [6:0] AID_PFX_SUM_CA   = 7'h0A;
  localparam logic [6:0] AID_PFX_DIFF_A   = 7'h16;
  localparam logic [6:0] AID_PFX_DIFF_BA  = 7'h0E;
  localparam logic [6:0] AID_PFX_CMP_A    = 7'h1E;
  localparam logic [5:0] AID_PFX_IMM_GRP  = 6'h20;
  localparam logic [6:0] AID_PFX_UNARY    = 7'h7B;
  localparam logic [5:0] AID_PFX_SPROD_I  = 6'h1A;
  localparam logic [2:0] AID_EXT_SUM      = 3'h0;
  localparam logic [2:0] AID_EXT_SUM_C    = 3'h2;
  localparam logic [2:0] AID_EXT_DIFF_B   = 3'h3;
  localparam logic [2:0] AID_EXT_DIFF     = 3'h5;
  localparam logic [2:0] AID_EXT_CMP      = 3'h7;
  localparam logic [2:0] AID_EXT_UPROD    = 3'h4;
  localparam logic [2:0] AID_EXT_SPROD    = 3'h5;
  localparam logic [2:0] AID_EXT_UQUOT    = 3'h6;
  localparam logic [1:0] AID_MOD_REG      = 2'h3;
  localparam int AID_BIT_W = 0;
  localparam int AID_BIT_D = 1;
  localparam int AID_BIT_S = 1;

  // clock counts
  localparam logic [5:0] AID_CLK_RR     = 6'd3;
  localparam logic [5:0] AID_CLK_RM     = 6'd10;
  localparam logic [5:0] AID_CLK_ACC_B  = 6'd3;
  localparam logic [5:0] AID_CLK_ACC_W  = 6'd4;
  localparam logic [5:0] AID_CLK_IMM_R  = 6'd4;
  localparam logic [5:0] AID_CLK_IMM_M  = 6'd16;
  localparam logic [5:0] AID_CLK_ASA    = 6'd8;
  localparam logic [5:0] AID_CLK_BSA    = 6'd4;
  localparam logic [5:0] AID_CLK_ADA    = 6'd7;
  localparam logic [5:0] AID_CLK_BDA    = 6'd4;
  localparam logic [5:0] AID_CLK_UP_RB  = 6'd26;
  localparam logic [5:0] AID_CLK_UP_RBX = 6'd28;
  localparam logic [5:0] AID_CLK_UP_RW  = 6'd35;
  localparam logic [5:0] AID_CLK_UP_RWX = 6'd37;
  localparam logic [5:0] AID_CLK_UP_MB  = 6'd32;
  localparam logic [5:0] AID_CLK_UP_MBX = 6'd34;
  localparam logic [5:0] AID_CLK_UP_MW  = 6'd41;
  localparam logic [5:0] AID_CLK_UP_MWX = 6'd43;
  localparam logic [5:0] AID_CLK_SP_RB  = 6'd25;
  localparam logic [5:0] AID_CLK_SP_RW  = 6'd34;
  localparam logic [5:0] AID_CLK_SP_MB  = 6'd31;
  localparam logic [5:0] AID_CLK_SP_MW  = 6'd40;
  localparam logic [5:0] AID_CLK_SPI_R  = 6'd22;
  localparam logic [5:0] AID_CLK_SPI_RX = 6'd25;
  localparam logic [5:0] AID_CLK_SPI_M  = 6'd29;
  localparam logic [5:0] AID_CLK_SPI_MX = 6'd32;
  localparam logic [5:0] AID_CLK_UQ_RB  = 6'd29;
  localparam logic [5:0] AID_CLK_UQ_RW  = 6'd38;
  localparam logic [5:0] AID_CLK_UQ_MB  = 6'd35;
  localparam logic [5:0] AID_CLK_UQ_MW  = 6'd44;

endpackage

/* design/aid_cycle_timer.sv */
`timescale 1ns/1ns
// counts execution clocks of one instruction
module aid_cycle_timer (
  input  wire logic       sys_clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic       load_in,
  input  wire logic [5:0] count_in,
  output logic            busy_out,
  output logic            done_out
);
  logic [5:0] cnt_r;
  logic [5:0] cnt_nxt;
  logic       done_r;
  logic       done_nxt;

  always_comb begin
    cnt_nxt  = cnt_r;
    done_nxt = 1'b0;
    if (load_in) begin
      cnt_nxt = count_in;
    end else if (cnt_r != 6'h00) begin
      cnt_nxt  = cnt_r - 6'h01;
      done_nxt = (cnt_r == 6'h01);
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      cnt_r  <= 6'h00;
      done_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  assign busy_out = (cnt_r != 6'h00);
  assign done_out = done_r;
endmodule

/* design/aid_decoder.sv */
`timescale 1ns/1ns
// How it works
// - sum register form: 000000dw, 3 clocks register, 10 memory
// - carry sum: 000100dw, extension 010, accumulator form; 3/10 clocks
// - accumulator immediates: second byte only when w=1; 3 byte, 4 word clocks
// - borrow difference immediate: ext 011 under 100000sw; second byte if sw=01; 4/16
// - difference: 001010dw 3/10 clocks; immediate variant ext 101
// - compare rm with register: 0011101w plus addressing byte, 3/10 clocks
// - compare accumulator immediate: 0011110w, word takes second byte; 3/4 clocks
// - ascii sum adjust 00110111, 8 clocks
// - bcd sum adjust 00100111, 4 clocks
// - ascii difference adjust, 7 clocks
// - bcd difference adjust 00101111, 4 clocks
// - unsigned product ext 100 under 1111011w; 26-28/35-37/32-34/41-43
// - signed product ext 101 under 1111011w; 25-28/34-37/31-34/40-43
// - signed immediate product 011010s1; second byte when s=0; 22-25/29-32
// - unsigned quotient ext 110 under 1111011w; 29/38/35/44 clocks
module aid_decoder
  import aid_pkg::*;
(
  // clock and reset
  input  wire logic            sys_clk_in,
  input  wire logic            sys_rst_in,
  // prefetch byte stream
  input  wire logic            byte_valid_in,
  input  wire logic [7:0]      byte_in,
  output logic                 byte_ready_out,
  // decoded instruction
  output aid_pkg::aid_dec_t    dec_out,
  output logic                 dec_valid_out,
  output logic                 illegal_out,
  // execution timing
  output logic                 exec_busy_out,
  output logic                 exec_done_out
);
  import aid_pkg::*;

  typedef enum logic [2:0] {
    AID_ST_OPC  = 3'b000,
    AID_ST_MODRM = 3'b001,
    AID_ST_IMLO = 3'b011,
    AID_ST_IMHI = 3'b010,
    AID_ST_EXEC = 3'b110
  } aid_state_t;

  aid_state_t st_r, st_nxt;
  aid_dec_t   dec_r, dec_nxt;
  logic [7:0] opc_r, opc_nxt;
  logic       valid_r, valid_nxt;
  logic       ill_r, ill_nxt;
  logic       ready_r, ready_nxt;
  logic       load;
  logic       t_busy, t_done;
  logic       busy_r, done_r;
  logic       take;

  // register/memory pair pick
  function automatic logic [5:0] pick(input logic mem, input logic [5:0] r, input logic [5:0] m);
    pick = mem ? m : r;
  endfunction

  // clock figures once the addressing byte is known
  function automatic void timing(input aid_op_t op, input aid_form_t form, input logic w,
                                 input logic mem, output logic [5:0] lo, output logic [5:0] hi);
    lo = AID_CLK_RR;
    hi = AID_CLK_RR;
    case (op)
      AID_OP_UPROD: begin
        lo = w ? pick(mem, AID_CLK_UP_RW, AID_CLK_UP_MW) : pick(mem, AID_CLK_UP_RB, AID_CLK_UP_MB);
        hi = w ? pick(mem, AID_CLK_UP_RWX, AID_CLK_UP_MWX) : pick(mem, AID_CLK_UP_RBX, AID_CLK_UP_MBX);
      end
      AID_OP_SPROD: begin
        lo = w ? pick(mem, AID_CLK_SP_RW, AID_CLK_SP_MW) : pick(mem, AID_CLK_SP_RB, AID_CLK_SP_MB);
        hi = w ? pick(mem, AID_CLK_UP_RWX, AID_CLK_UP_MWX) : pick(mem, AID_CLK_UP_RBX, AID_CLK_UP_MBX);
      end
      AID_OP_SPROD_I: begin
        lo = pick(mem, AID_CLK_SPI_R, AID_CLK_SPI_M);
        hi = pick(mem, AID_CLK_SPI_RX, AID_CLK_SPI_MX);
      end
      AID_OP_UQUOT: begin
        lo = w ? pick(mem, AID_CLK_UQ_RW, AID_CLK_UQ_MW) : pick(mem, AID_CLK_UQ_RB, AID_CLK_UQ_MB);
        hi = lo;
      end
      default: begin
        if (form == AID_FORM_IMM) begin
          lo = pick(mem, AID_CLK_IMM_R, AID_CLK_IMM_M);
        end else begin
          lo = pick(mem, AID_CLK_RR, AID_CLK_RM);
        end
        hi = lo;
      end
    endcase
  endfunction

  // wide immediate needed for the given form
  function automatic logic imm_wide(input aid_op_t op, input aid_form_t form, input logic [7:0] opc);
    if (op == AID_OP_SPROD_I) begin
      imm_wide = ~opc[AID_BIT_S];
    end else if (form == AID_FORM_IMM) begin
      imm_wide = (opc[1:0] == 2'b01);
    end else begin
      imm_wide = opc[AID_BIT_W];
    end
  endfunction

  assign take = byte_valid_in & ready_r;

  always_comb begin
    logic [5:0] lo;
    logic [5:0] hi;
    lo        = 6'h00;
    hi        = 6'h00;
    st_nxt    = st_r;
    dec_nxt   = dec_r;
    opc_nxt   = opc_r;
    valid_nxt = 1'b0;
    ill_nxt   = 1'b0;
    load      = 1'b0;
    case (st_r)
      AID_ST_OPC: begin
        if (take) begin
          opc_nxt             = byte_in;
          dec_nxt             = '0;
          dec_nxt.word        = byte_in[AID_BIT_W];
          dec_nxt.reg_is_dst  = byte_in[AID_BIT_D];
          dec_nxt.form        = AID_FORM_RM;
          st_nxt              = AID_ST_MODRM;
          if (byte_in[7:2] == AID_PFX_SUM) dec_nxt.op = AID_OP_SUM;
          else if (byte_in[7:2] == AID_PFX_SUM_C) dec_nxt.op = AID_OP_SUM_C;
          else if (byte_in[7:2] == AID_PFX_DIFF) dec_nxt.op = AID_OP_DIFF;
          else if (byte_in[7:2] == AID_PFX_DIFF_B) dec_nxt.op = AID_OP_DIFF_B;
          else if (byte_in[7:1] == AID_PFX_CMP_RM || byte_in[7:1] == AID_PFX_CMP_MR) begin
            dec_nxt.op = AID_OP_COMPARE;
          end else if (byte_in[7:2] == AID_PFX_IMM_GRP) dec_nxt.form = AID_FORM_IMM;
          else if (byte_in[7:1] == AID_PFX_UNARY) dec_nxt.form = AID_FORM_ONE;
          else if (byte_in[7:2] == AID_PFX_SPROD_I && byte_in[AID_BIT_W]) begin
            dec_nxt.op = AID_OP_SPROD_I;
            dec_nxt.reg_is_dst = 1'b1;
          end else begin
            dec_nxt.form = AID_FORM_ACC;
            st_nxt = AID_ST_IMLO;
            lo = byte_in[AID_BIT_W] ? AID_CLK_ACC_W : AID_CLK_ACC_B;
            dec_nxt.clk_min = lo;
            dec_nxt.clk_max = lo;
            if (byte_in[7:1] == AID_PFX_SUM_A) dec_nxt.op = AID_OP_SUM;
            else if (byte_in[7:1] == AID_PFX_SUM_CA) dec_nxt.op = AID_OP_SUM_C;
            else if (byte_in[7:1] == AID_PFX_DIFF_A) dec_nxt.op = AID_OP_DIFF;
            else if (byte_in[7:1] == AID_PFX_DIFF_BA) dec_nxt.op = AID_OP_DIFF_B;
            else if (byte_in[7:1] == AID_PFX_CMP_A) dec_nxt.op = AID_OP_COMPARE;
            else begin
              dec_nxt.form = AID_FORM_ONE;
              dec_nxt.word = 1'b0;
              st_nxt = AID_ST_EXEC;
              case (byte_in)
                AID_OPC_ASCII_SA: begin dec_nxt.op = AID_OP_ASCII_SA; lo = AID_CLK_ASA; end
                AID_OPC_BCD_SA:   begin dec_nxt.op = AID_OP_BCD_SA;   lo = AID_CLK_BSA; end
                AID_OPC_ASCII_DA: begin dec_nxt.op = AID_OP_ASCII_DA; lo = AID_CLK_ADA; end
                AID_OPC_BCD_DA:   begin dec_nxt.op = AID_OP_BCD_DA;   lo = AID_CLK_BDA; end
                default: begin
                  ill_nxt = 1'b1;
                  st_nxt  = AID_ST_OPC;
                end
              endcase
              dec_nxt.clk_min = lo;
              dec_nxt.clk_max = lo;
              load      = ~ill_nxt;
              valid_nxt = ~ill_nxt;
            end
          end
        end
      end
      AID_ST_MODRM: begin
        if (take) begin
          dec_nxt.mod_f = byte_in[7:6];
          dec_nxt.reg_f = byte_in[5:3];
          dec_nxt.rm_f  = byte_in[2:0];
          dec_nxt.mem   = (byte_in[7:6] != AID_MOD_REG);
          st_nxt        = AID_ST_EXEC;
          if (dec_r.form == AID_FORM_IMM) begin
            st_nxt = AID_ST_IMLO;
            case (byte_in[5:3])
              AID_EXT_SUM:    dec_nxt.op = AID_OP_SUM;
              AID_EXT_SUM_C:  dec_nxt.op = AID_OP_SUM_C;
              AID_EXT_DIFF_B: dec_nxt.op = AID_OP_DIFF_B;
              AID_EXT_DIFF:   dec_nxt.op = AID_OP_DIFF;
              AID_EXT_CMP:    dec_nxt.op = AID_OP_COMPARE;
              default:        st_nxt = AID_ST_OPC;
            endcase
          end else if (dec_r.form == AID_FORM_ONE) begin
            case (byte_in[5:3])
              AID_EXT_UPROD: dec_nxt.op = AID_OP_UPROD;
              AID_EXT_SPROD: dec_nxt.op = AID_OP_SPROD;
              AID_EXT_UQUOT: dec_nxt.op = AID_OP_UQUOT;
              default:       st_nxt = AID_ST_OPC;
            endcase
          end else if (dec_r.op == AID_OP_SPROD_I) begin
            st_nxt = AID_ST_IMLO;
          end
          timing(dec_nxt.op, dec_r.form, dec_r.word, dec_nxt.mem, lo, hi);
          dec_nxt.clk_min = lo;
          dec_nxt.clk_max = hi;
          if (st_nxt == AID_ST_OPC) begin
            ill_nxt = 1'b1;
          end else if (st_nxt == AID_ST_EXEC) begin
            load      = 1'b1;
            valid_nxt = 1'b1;
          end
        end
      end
      AID_ST_IMLO: begin
        if (take) begin
          dec_nxt.imm = {{8{byte_in[7]}}, byte_in};
          if (imm_wide(dec_r.op, dec_r.form, opc_r)) begin
            st_nxt = AID_ST_IMHI;
          end else begin
            st_nxt    = AID_ST_EXEC;
            load      = 1'b1;
            valid_nxt = 1'b1;
          end
        end
      end
      AID_ST_IMHI: begin
        if (take) begin
          dec_nxt.imm[15:8] = byte_in;
          st_nxt    = AID_ST_EXEC;
          load      = 1'b1;
          valid_nxt = 1'b1;
        end
      end
      AID_ST_EXEC: begin
        if (t_done) begin
          st_nxt = AID_ST_OPC;
        end
      end
      default: st_nxt = AID_ST_OPC;
    endcase
    ready_nxt = (st_nxt != AID_ST_EXEC);
  end

  aid_cycle_timer u_timer (
    .sys_clk_in (sys_clk_in),
    .sys_rst_in (sys_rst_in),
    .load_in    (load),
    .count_in   (dec_nxt.clk_min),
    .busy_out   (t_busy),
    .done_out   (t_done)
  );

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      st_r    <= AID_ST_OPC;
      dec_r   <= '0;
      opc_r   <= 8'h00;
      valid_r <= 1'b0;
      ill_r   <= 1'b0;
      ready_r <= 1'b1;
      busy_r  <= 1'b0;
      done_r  <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      dec_r   <= dec_nxt;
      opc_r   <= opc_nxt;
      valid_r <= valid_nxt;
      ill_r   <= ill_nxt;
      ready_r <= ready_nxt;
      busy_r  <= t_busy | load;
      done_r  <= t_done;
    end
  end

  assign byte_ready_out = ready_r;
  assign dec_out        = dec_r;
  assign dec_valid_out  = valid_r;
  assign illegal_out    = ill_r;
  assign exec_busy_out  = busy_r;
  assign exec_done_out  = done_r;

  property p_bcd_sum_4;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      (valid_r && dec_r.op == AID_OP_BCD_SA) |-> dec_r.clk_min == 6'd4;
  endproperty
  a_bcd_sum_4: assert property (p_bcd_sum_4) else $error("bcd sum adjust not 4 clocks");

  property p_ascii_sum_8;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      (valid_r && dec_r.op == AID_OP_ASCII_SA) |-> dec_r.clk_min == 6'd8;
  endproperty
  a_ascii_sum_8: assert property (p_ascii_sum_8) else $error("ascii sum adjust not 8 clocks");

  // done shows one register stage after the timer's last count
  sequence s_ascii_diff_run;
    ##7 (exec_done_out || exec_busy_out) ##1 exec_done_out;
  endsequence
  property p_ascii_diff_7;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      (valid_r && dec_r.op == AID_OP_ASCII_DA) |-> s_ascii_diff_run;
  endproperty
  a_ascii_diff_7: assert property (p_ascii_diff_7) else $error("ascii diff adjust timing");

  property p_rm_pair;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      (valid_r && dec_r.form == AID_FORM_RM && dec_r.op inside {AID_OP_SUM, AID_OP_DIFF, AID_OP_COMPARE})
      |-> dec_r.clk_min == (dec_r.mem ? 6'd10 : 6'd3);
  endproperty
  a_rm_pair: assert property (p_rm_pair) else $error("register form clock pair wrong");

  property p_imm_pair;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      (valid_r && dec_r.form == AID_FORM_IMM) |-> dec_r.clk_min == (dec_r.mem ? 6'd16 : 6'd4);
  endproperty
  a_imm_pair: assert property (p_imm_pair) else $error("immediate form clock pair wrong");

  property p_acc_clk;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      (valid_r && dec_r.form == AID_FORM_ACC) |-> dec_r.clk_min == (dec_r.word ? 6'd4 : 6'd3);
  endproperty
  a_acc_clk: assert property (p_acc_clk) else $error("accumulator form clocks wrong");

  property p_uquot;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      (valid_r && dec_r.op == AID_OP_UQUOT && !dec_r.mem && !dec_r.word) |-> dec_r.clk_min == 6'd29;
  endproperty
  a_uquot: assert property (p_uquot) else $error("quotient register byte not 29");

  property p_sprod_i;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      (valid_r && dec_r.op == AID_OP_SPROD_I) |-> dec_r.clk_max == dec_r.clk_min + 6'd3;
  endproperty
  a_sprod_i: assert property (p_sprod_i) else $error("immediate product range wrong");

  sequence s_exec_start;
    valid_r;
  endsequence
  property p_busy_hold;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      s_exec_start |-> !byte_ready_out;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("bytes taken during execution");
endmodule

/* test/aid_decoder_tb.sv */
`timescale 1ns/1ns
module aid_decoder_tb;
  import aid_pkg::*;

  typedef struct packed {
    logic        ill;
    aid_op_t     op;
    logic        has_w;
    logic        word;
    logic        has_rm;
    logic        mem;
    logic        has_d;
    logic        dst;
    logic [7:0]  mrm;
    logic [5:0]  lo;
    logic [5:0]  hi;
    logic        has_imm;
    logic [15:0] imm;
  } aid_tb_exp_t;

  // register byte, register word, memory byte, memory word
  localparam logic [11:0] UCLK [12] = '{
    {6'h1A, 6'h1C}, {6'h23, 6'h25}, {6'h20, 6'h22}, {6'h29, 6'h2B},
    {6'h19, 6'h1C}, {6'h22, 6'h25}, {6'h1F, 6'h22}, {6'h28, 6'h2B},
    {6'h1D, 6'h1D}, {6'h26, 6'h26}, {6'h23, 6'h23}, {6'h2C, 6'h2C}};

  logic        sys_clk_in    = 1'b0;
  logic        sys_rst_in    = 1'b1;
  logic        byte_valid_in = 1'b0;
  logic [7:0]  byte_in       = 8'h00;
  logic        byte_ready_out;
  aid_dec_t    dec_out;
  logic        dec_valid_out;
  logic        illegal_out;
  logic        exec_busy_out;
  logic        exec_done_out;
  aid_tb_exp_t exp_q [$];
  aid_tb_exp_t cur;
  aid_tb_exp_t act;
  logic [7:0]  bq [$];
  int          fail_count = 0;
  int          n_compared = 0;
  int          since_dec  = 0;
  logic        armed      = 1'b0;
  logic [5:0]  last_lo    = 6'h00;

  always #4 sys_clk_in = ~sys_clk_in;

  aid_decoder aid_decoder_i (
    .sys_clk_in     (sys_clk_in),
    .sys_rst_in     (sys_rst_in),
    .byte_valid_in  (byte_valid_in),
    .byte_in        (byte_in),
    .byte_ready_out (byte_ready_out),
    .dec_out        (dec_out),
    .dec_valid_out  (dec_valid_out),
    .illegal_out    (illegal_out),
    .exec_busy_out  (exec_busy_out),
    .exec_done_out  (exec_done_out)
  );

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [63:0] got, input logic [63:0] want);
    n_compared++;
    if (got !== want) begin
      fail_count++;
      $display("BAD t=%0t got=%h want=%h", $time, got, want);
    end
  endtask

  // result watcher: pairs each decode or refusal with the oldest note
  always @(posedge sys_clk_in) begin
    if (sys_rst_in === 1'b1) begin
      armed = 1'b0;
    end else begin
      if (armed) since_dec++;
      if (exec_busy_out === 1'b1) check(64'(byte_ready_out), 64'h0);
      if (exec_done_out === 1'b1) begin
        check(64'(armed && since_dec >= int'(last_lo) && since_dec <= int'(last_lo) + 2), 64'h1);
        armed = 1'b0;
      end
      if (dec_valid_out === 1'b1 || illegal_out === 1'b1) begin
        if (exp_q.size() == 0) begin
          check(64'({dec_valid_out, illegal_out}), 64'h0);
        end else begin
          cur = exp_q.pop_front();
          act = cur;
          act.ill = illegal_out | ~dec_valid_out;
          if (!cur.ill) begin
            act.op = dec_out.op;
            act.lo = dec_out.clk_min;
            act.hi = dec_out.clk_max;
            if (cur.has_w) act.word = dec_out.word;
            if (cur.has_d) act.dst = dec_out.reg_is_dst;
            if (cur.has_imm) act.imm = dec_out.imm;
            if (cur.has_rm) begin
              act.mem = dec_out.mem;
              act.mrm = {dec_out.mod_f, dec_out.reg_f, dec_out.rm_f};
            end
            armed = 1'b1;
            since_dec = 0;
            last_lo = cur.lo;
          end
          check(64'(act), 64'(cur));
        end
      end
    end
  end

  task automatic put(input logic [7:0] b);
    int k;
    byte_valid_in = 1'b1;
    byte_in = b;
    for (k = 0; k < 200; k++) begin
      @(posedge sys_clk_in);
      if (byte_ready_out === 1'b1) break;
    end
    #1;
    if (k == 200) begin
      fail_count++;
      results();
    end
  endtask

  task automatic issue(input aid_tb_exp_t e);
    exp_q.push_back(e);
    while (bq.size() > 0) put(bq.pop_front());
    if ($urandom_range(1) == 1) begin
      byte_valid_in = 1'b0;
      byte_in = 8'($urandom);
      @(posedge sys_clk_in);
      #1;
    end
  endtask

  function automatic aid_tb_exp_t mk(input aid_op_t op, input logic [5:0] lo, input logic [5:0] hi);
    aid_tb_exp_t e;
    e = '0;
    e.op = op;
    e.lo = lo;
    e.hi = hi;
    return e;
  endfunction

  task automatic add_rm(inout aid_tb_exp_t e, input logic m, input logic [2:0] rg);
    logic [2:0] r;
    r = 3'($urandom);
    // memory forms avoid direct addressing so no displacement follows
    if (m && r == 3'h6) r = 3'h7;
    e.has_rm = 1'b1;
    e.mem = m;
    e.mrm = {m ? 2'h0 : 2'h3, rg, r};
    bq.push_back(e.mrm);
  endtask

  task automatic add_imm(inout aid_tb_exp_t e, input logic two);
    logic [15:0] v;
    v = 16'($urandom);
    bq.push_back(v[7:0]);
    if (two) bq.push_back(v[15:8]);
    e.has_imm = 1'b1;
    e.imm = two ? v : {{8{v[7]}}, v[7:0]};
  endtask

  task automatic rm_form(input aid_op_t op, input logic [7:0] base, input logic m);
    logic [1:0]  dw;
    aid_tb_exp_t e;
    dw = 2'($urandom);
    e = mk(op, m ? 6'h0A : 6'h03, m ? 6'h0A : 6'h03);
    e.has_w = 1'b1;
    e.word = dw[0];
    e.has_d = 1'b1;
    e.dst = dw[1];
    bq.push_back(base | {6'h00, dw});
    add_rm(e, m, 3'($urandom));
    issue(e);
  endtask

  task automatic acc_form(input aid_op_t op, input logic [7:0] base, input logic w);
    aid_tb_exp_t e;
    e = mk(op, w ? 6'h04 : 6'h03, w ? 6'h04 : 6'h03);
    e.has_w = 1'b1;
    e.word = w;
    bq.push_back(base | {7'h00, w});
    add_imm(e, w);
    issue(e);
  endtask

  task automatic imm_form(input aid_op_t op, input logic [2:0] ext, input logic [1:0] sw, input logic m);
    aid_tb_exp_t e;
    e = mk(op, m ? 6'h10 : 6'h04, m ? 6'h10 : 6'h04);
    e.has_w = 1'b1;
    e.word = sw[0];
    bq.push_back(8'h80 | {6'h00, sw});
    add_rm(e, m, ext);
    add_imm(e, sw == 2'h1);
    issue(e);
  endtask

  task automatic un_form(input aid_op_t op, input logic [2:0] ext, input int idx, input logic m, input logic w);
    aid_tb_exp_t e;
    logic [11:0] c;
    c = UCLK[idx * 4 + int'(m) * 2 + int'(w)];
    e = mk(op, c[11:6], c[5:0]);
    e.has_w = 1'b1;
    e.word = w;
    bq.push_back(8'hF6 | {7'h00, w});
    add_rm(e, m, ext);
    issue(e);
  endtask

  task automatic spi_form(input logic s, input logic m);
    aid_tb_exp_t e;
    e = mk(AID_OP_SPROD_I, m ? 6'h1D : 6'h16, m ? 6'h20 : 6'h19);
    bq.push_back(8'h69 | {6'h00, s, 1'b0});
    add_rm(e, m, 3'($urandom));
    add_imm(e, !s);
    issue(e);
  endtask

  task automatic one(input logic [7:0] b, input aid_op_t op, input logic [5:0] c);
    bq.push_back(b);
    issue(mk(op, c, c));
  endtask

  task automatic bad(input logic [7:0] b, input logic [2:0] ext, input logic with_rm);
    aid_tb_exp_t e;
    e = '0;
    e.ill = 1'b1;
    bq.push_back(b);
    if (with_rm) bq.push_back({2'h3, ext, 3'h1});
    issue(e);
  endtask

  initial begin
    void'($urandom(32'h11B2));
    repeat (20) @(posedge sys_clk_in);
    #1;
    sys_rst_in = 1'b0;
    one(8'h37, AID_OP_ASCII_SA, 6'h08);
    one(8'h27, AID_OP_BCD_SA, 6'h04);
    one(8'h3F, AID_OP_ASCII_DA, 6'h07);
    one(8'h2F, AID_OP_BCD_DA, 6'h04);
    for (int m = 0; m < 2; m++) begin
      for (int k = 0; k < 2; k++) begin
        rm_form(AID_OP_SUM, 8'h00, 1'(m));
        rm_form(AID_OP_SUM_C, 8'h10, 1'(m));
        rm_form(AID_OP_DIFF, 8'h28, 1'(m));
        rm_form(AID_OP_DIFF_B, 8'h18, 1'(m));
        rm_form(AID_OP_COMPARE, 8'h38, 1'(m));
        acc_form(AID_OP_SUM, 8'h04, 1'(k));
        acc_form(AID_OP_SUM_C, 8'h14, 1'(k));
        acc_form(AID_OP_DIFF, 8'h2C, 1'(k));
        acc_form(AID_OP_DIFF_B, 8'h1C, 1'(k));
        acc_form(AID_OP_COMPARE, 8'h3C, 1'(k));
        un_form(AID_OP_UPROD, 3'h4, 0, 1'(m), 1'(k));
        un_form(AID_OP_SPROD, 3'h5, 1, 1'(m), 1'(k));
        un_form(AID_OP_UQUOT, 3'h6, 2, 1'(m), 1'(k));
        spi_form(1'(k), 1'(m));
      end
      for (int sw = 0; sw < 4; sw++) begin
        imm_form(AID_OP_SUM, 3'h0, 2'(sw), 1'(m));
        imm_form(AID_OP_SUM_C, 3'h2, 2'(sw), 1'(m));
        imm_form(AID_OP_DIFF_B, 3'h3, 2'(sw), 1'(m));
        imm_form(AID_OP_DIFF, 3'h5, 2'(sw), 1'(m));
        imm_form(AID_OP_COMPARE, 3'h7, 2'(sw), 1'(m));
      end
    end
    bad(8'hF4, 3'h0, 1'b0);
    bad(8'hF7, 3'h7, 1'b1);
    bad(8'hF7, 3'h3, 1'b1);
    bad(8'h81, 3'h4, 1'b1);
    one(8'h37, AID_OP_ASCII_SA, 6'h08);
    // reset in the middle of a long execution
    un_form(AID_OP_UQUOT, 3'h6, 2, 1'b1, 1'b1);
    byte_valid_in = 1'b0;
    repeat (10) @(posedge sys_clk_in);
    #1;
    sys_rst_in = 1'b1;
    repeat (2) @(posedge sys_clk_in);
    #1;
    sys_rst_in = 1'b0;
    check(64'({exec_busy_out, byte_ready_out, dec_valid_out}), 64'h2);
    check(64'(dec_out), 64'h0);
    one(8'h2F, AID_OP_BCD_DA, 6'h04);
    byte_valid_in = 1'b0;
    for (int k = 0; k < 100 && (exp_q.size() > 0 || armed); k++) @(posedge sys_clk_in);
    if (exp_q.size() > 0 || armed) fail_count++;
    results();
  end
endmodule
